// ---- pjsc_regs.svh ----
`ifndef PJSC_REGS_SVH
`define PJSC_REGS_SVH
`define PJSC_JOB_W 4
`define PJSC_NUM_EN 3
`define PJSC_NUM_TEST 3
`define PJSC_TM_START 3'h0
`define PJSC_TM_STOP 3'h1
`define PJSC_TM_END 3'h2
`define PJSC_TM_CONT 3'h3
`define PJSC_TM_ENABLE 3'h4
`define PJSC_JOB_RST 4'h0
`endif

// ---- pjsc_pkg.sv ----
`include "pjsc_regs.svh"
package pjsc_pkg;
  typedef enum logic [1:0]
  {
    PJSC_IDLE = 2'b00,
    PJSC_PRESS = 2'b01,
    PJSC_RETURN = 2'b11,
    PJSC_LOCKED = 2'b10
  } pjsc_phase_t;

  typedef logic [2:0] pjsc_tmode_t;

  typedef struct packed
  {
    logic start;
    logic stop;
    logic origin;
    logic key_reset;
    logic ext_reset;
    logic [`PJSC_NUM_EN-1:0] enable;
    logic [`PJSC_NUM_TEST-1:0] test;
    logic [`PJSC_JOB_W-1:0] job_code;
  } pjsc_pins_t;

  typedef struct packed
  {
    logic job_select_on;
    logic key_reset_off;
    logic exclude_checks;
    logic [`PJSC_NUM_EN-1:0] enable_used;
    logic [`PJSC_NUM_TEST-1:0] test_used;
    pjsc_tmode_t [`PJSC_NUM_TEST-1:0] test_mode;
  } pjsc_cfg_t;

  typedef struct packed
  {
    pjsc_pins_t s1;
    pjsc_pins_t s2;
    logic start_d;
    logic stop_d;
    pjsc_phase_t phase;
    logic [`PJSC_JOB_W-1:0] job;
    logic [`PJSC_JOB_W-1:0] code_d;
    logic go;
    logic good;
    logic rejected;
    logic locked;
    logic no_enable;
    logic bad;
    logic trigger;
  } pjsc_state_t;
endpackage

// ---- pjsc_core.sv ----
`include "pjsc_regs.svh"
module pjsc_core
(
  input wire logic clk,
  input wire logic nrst,
  input wire pjsc_pkg::pjsc_pins_t pins,
  input wire pjsc_pkg::pjsc_cfg_t cfg,
  output logic [`PJSC_JOB_W-1:0] active_job,
  output logic press_go,
  output logic piece_good,
  output logic piece_rejected,
  output logic reject_locked,
  output logic enable_missing,
  output logic test_trigger
);
  import pjsc_pkg::*;

  pjsc_state_t st_reg;
  pjsc_state_t st_next;
  pjsc_pins_t p;
  logic start_rise;
  logic stop_rise;
  logic clear_lock;
  logic checks_on;
  logic consent_ok;
  logic [`PJSC_NUM_TEST-1:0] fail_start;
  logic [`PJSC_NUM_TEST-1:0] fail_stop;
  logic [`PJSC_NUM_TEST-1:0] fail_end;
  logic [`PJSC_NUM_TEST-1:0] fail_cont;
  logic [`PJSC_NUM_TEST-1:0] as_consent;

  assign p = st_reg.s2;
  assign start_rise = p.start && !st_reg.start_d;
  assign stop_rise = p.stop && !st_reg.stop_d;
  assign checks_on = !cfg.exclude_checks;
  // key path gated by option; external input always clears
  assign clear_lock = p.ext_reset || (p.key_reset && !cfg.key_reset_off);

  genvar gi;
  generate
    for (gi = 0; gi < `PJSC_NUM_TEST; gi = gi + 1)
    begin : g_test
      logic used;
      logic absent;
      assign used = checks_on && cfg.test_used[gi];
      assign absent = !p.test[gi];
      assign fail_start[gi] = used && absent &&
        (cfg.test_mode[gi] == `PJSC_TM_START);
      assign fail_stop[gi] = used && absent &&
        (cfg.test_mode[gi] == `PJSC_TM_STOP);
      assign fail_end[gi] = used && absent &&
        (cfg.test_mode[gi] == `PJSC_TM_END);
      assign fail_cont[gi] = used && absent &&
        (cfg.test_mode[gi] == `PJSC_TM_CONT);
      assign as_consent[gi] = used && absent &&
        (cfg.test_mode[gi] == `PJSC_TM_ENABLE);
    end
  endgenerate

  // all used consents present; excluded jobs skip the check
  assign consent_ok = !checks_on ||
    (((~p.enable & cfg.enable_used) == '0) && (as_consent == '0));

  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = pins;
    st_next.s2 = st_reg.s1;
    st_next.start_d = p.start;
    st_next.stop_d = p.stop;
    st_next.code_d = p.job_code;
    // code inputs form the job number directly; held off during start
    if (cfg.job_select_on && !p.start && p.job_code != st_reg.code_d)
    begin
      st_next.job = p.job_code;
    end
    case (st_reg.phase)
      PJSC_IDLE:
      begin
        st_next.trigger = 1'b0;
        if (start_rise)
        begin
          st_next.good = 1'b0;
          st_next.rejected = 1'b0;
          st_next.no_enable = !consent_ok;
          if (consent_ok)
          begin
            st_next.phase = PJSC_PRESS;
            st_next.go = 1'b1;
            st_next.bad = |fail_start;
            // trigger drives the external check behind test one
            st_next.trigger = checks_on && cfg.test_used[0];
          end
        end
        else if (consent_ok)
        begin
          st_next.no_enable = 1'b0;
        end
      end
      PJSC_PRESS:
      begin
        if (|fail_cont)
        begin
          st_next.bad = 1'b1;
        end
        if (stop_rise)
        begin
          st_next.go = 1'b0;
          st_next.trigger = 1'b0;
          st_next.phase = PJSC_RETURN;
          if (|fail_stop)
          begin
            st_next.bad = 1'b1;
          end
        end
      end
      PJSC_RETURN:
      begin
        // results wait for rest position, never during pressing
        if (p.origin)
        begin
          if (st_reg.bad || (|fail_end))
          begin
            st_next.rejected = 1'b1;
            st_next.locked = 1'b1;
            st_next.phase = PJSC_LOCKED;
          end
          else
          begin
            st_next.good = 1'b1;
            st_next.phase = PJSC_IDLE;
          end
        end
      end
      PJSC_LOCKED:
      begin
        st_next.go = 1'b0;
        if (clear_lock)
        begin
          st_next.locked = 1'b0;
          st_next.rejected = 1'b0;
          st_next.bad = 1'b0;
          st_next.phase = PJSC_IDLE;
        end
      end
      default:
      begin
        st_next.phase = PJSC_IDLE;
        st_next.go = 1'b0;
      end
    endcase
    if (st_next.no_enable || st_next.locked)
    begin
      st_next.go = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign active_job = st_reg.job;
  assign press_go = st_reg.go;
  assign piece_good = st_reg.good;
  assign piece_rejected = st_reg.rejected;
  assign reject_locked = st_reg.locked;
  assign enable_missing = st_reg.no_enable;
  assign test_trigger = st_reg.trigger;

  property p_go_safe;
    @(posedge clk) disable iff (!nrst)
      (reject_locked || enable_missing) |-> !press_go;
  endproperty
  a_go_safe: assert property (p_go_safe) else $error("go while blocked");

  property p_result_rest;
    @(posedge clk) disable iff (!nrst)
      $rose(piece_good) || $rose(piece_rejected) |->
        $past(st_reg.phase) == PJSC_RETURN && $past(p.origin);
  endproperty
  a_result_rest: assert property (p_result_rest) else $error("early result");

  property p_lock_on_reject;
    @(posedge clk) disable iff (!nrst)
      $rose(piece_rejected) |-> reject_locked;
  endproperty
  a_lock_on_reject: assert property (p_lock_on_reject) else $error("no lock");

  property p_lock_hold;
    @(posedge clk) disable iff (!nrst)
      reject_locked && !clear_lock |=> reject_locked;
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock lost");

  property p_key_off;
    @(posedge clk) disable iff (!nrst)
      reject_locked && cfg.key_reset_off && !p.ext_reset |=> reject_locked;
  endproperty
  a_key_off: assert property (p_key_off) else $error("key cleared lock");

  property p_lock_clear;
    @(posedge clk) disable iff (!nrst)
      reject_locked && p.ext_reset |=> !reject_locked;
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("lock kept");

  property p_job_hold;
    @(posedge clk) disable iff (!nrst)
      p.start |=> $stable(active_job);
  endproperty
  a_job_hold: assert property (p_job_hold) else $error("job moved");

  property p_job_follow;
    @(posedge clk) disable iff (!nrst)
      cfg.job_select_on && !p.start && p.job_code != st_reg.code_d
        |=> active_job == $past(p.job_code);
  endproperty
  a_job_follow: assert property (p_job_follow) else $error("job not set");

  property p_go_stop;
    @(posedge clk) disable iff (!nrst)
      press_go && stop_rise |=> !press_go;
  endproperty
  a_go_stop: assert property (p_go_stop) else $error("go kept at stop");

  property p_missing;
    @(posedge clk) disable iff (!nrst)
      st_reg.phase == PJSC_IDLE && start_rise && !consent_ok
        |=> enable_missing && !press_go;
  endproperty
  a_missing: assert property (p_missing) else $error("missing not flagged");

  property p_go_rise;
    @(posedge clk) disable iff (!nrst)
      st_reg.phase == PJSC_IDLE && start_rise && consent_ok |=> press_go;
  endproperty
  a_go_rise: assert property (p_go_rise) else $error("go not raised");

  property p_trigger_go;
    @(posedge clk) disable iff (!nrst)
      test_trigger |-> press_go;
  endproperty
  a_trigger_go: assert property (p_trigger_go) else $error("stray trigger");

  property p_trigger_off;
    @(posedge clk) disable iff (!nrst)
      cfg.exclude_checks && st_reg.phase == PJSC_IDLE && start_rise
        |=> !test_trigger;
  endproperty
  a_trigger_off: assert property (p_trigger_off) else $error("trig excl");

  property p_one_result;
    @(posedge clk) disable iff (!nrst)
      !(piece_good && piece_rejected);
  endproperty
  a_one_result: assert property (p_one_result) else $error("two results");

  property p_no_result_press;
    @(posedge clk) disable iff (!nrst)
      st_reg.phase == PJSC_PRESS |-> !piece_good && !piece_rejected;
  endproperty
  a_no_result_press: assert property (p_no_result_press) else $error("result");

  property p_lock_phase;
    @(posedge clk) disable iff (!nrst)
      reject_locked |-> st_reg.phase == PJSC_LOCKED;
  endproperty
  a_lock_phase: assert property (p_lock_phase) else $error("lock phase");

  property p_lock_start;
    @(posedge clk) disable iff (!nrst)
      st_reg.phase == PJSC_LOCKED && start_rise && !clear_lock
        |=> !press_go && reject_locked;
  endproperty
  a_lock_start: assert property (p_lock_start) else $error("start in lock");

  property p_cont_reject;
    @(posedge clk) disable iff (!nrst)
      st_reg.phase == PJSC_PRESS && (|fail_cont) |=> st_reg.bad;
  endproperty
  a_cont_reject: assert property (p_cont_reject) else $error("cont miss");

  property p_stop_reject;
    @(posedge clk) disable iff (!nrst)
      st_reg.phase == PJSC_PRESS && stop_rise && (|fail_stop) |=> st_reg.bad;
  endproperty
  a_stop_reject: assert property (p_stop_reject) else $error("stop miss");

  property p_start_sample;
    @(posedge clk) disable iff (!nrst)
      st_reg.phase == PJSC_IDLE && start_rise && consent_ok
        |=> st_reg.bad == $past(|fail_start);
  endproperty
  a_start_sample: assert property (p_start_sample) else $error("start miss");

  property p_end_reject;
    @(posedge clk) disable iff (!nrst)
      st_reg.phase == PJSC_RETURN && p.origin && (|fail_end)
        |=> piece_rejected && reject_locked;
  endproperty
  a_end_reject: assert property (p_end_reject) else $error("end miss");

  property p_job_off;
    @(posedge clk) disable iff (!nrst)
      !cfg.job_select_on |=> $stable(active_job);
  endproperty
  a_job_off: assert property (p_job_off) else $error("job moved off");

  property p_enable_consent;
    @(posedge clk) disable iff (!nrst)
      st_reg.phase == PJSC_IDLE && start_rise && (as_consent != '0)
        |=> enable_missing;
  endproperty
  a_enable_consent: assert property (p_enable_consent) else $error("cons");

  property p_missing_clear;
    @(posedge clk) disable iff (!nrst)
      st_reg.phase == PJSC_IDLE && !start_rise && consent_ok
        |=> !enable_missing;
  endproperty
  a_missing_clear: assert property (p_missing_clear) else $error("stuck");

  property p_key_clear;
    @(posedge clk) disable iff (!nrst)
      reject_locked && p.key_reset && !cfg.key_reset_off |=> !reject_locked;
  endproperty
  a_key_clear: assert property (p_key_clear) else $error("key ignored");
endmodule

// ---- pjsc_plc.sv ----
// machine-side model: drives start, stop, cylinder rest and test sensor 1
module pjsc_plc
(
  input wire logic clk,
  output logic start,
  output logic stop,
  output logic origin,
  output logic test_ok
);
  timeunit 1ns;
  timeprecision 1ps;

  // cylinder starts at rest; the sensor reports a passed check
  initial
  begin
    {start, stop, origin, test_ok} = 4'h3;
  end

  // all four pins set in one call, just after the edge; the caller keeps the
  // order start, stop, rest, so the model never commands a stroke backwards
  task automatic step(input logic [3:0] v);
    @(posedge clk);
    #1;
    {start, stop, origin, test_ok} = v;
  endtask
endmodule

// ---- pjsc_core_test.sv ----
module pjsc_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic key_rst = 1'b0;
  logic ext_rst = 1'b0;
  logic [2:0] en = 3'h7;
  logic [3:0] code = 4'h0;
  logic [1:0] t_hi = 2'h3;
  logic p_start, p_stop, p_origin, p_test;
  pjsc_pkg::pjsc_pins_t pins;
  pjsc_pkg::pjsc_cfg_t cfg = '0;
  logic [3:0] active_job;
  logic go, good, rej, locked, missing, trig;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [3:0] codes [4] = '{4'h5, 4'ha, 4'hf, 4'h3};

  always #2.5 clk = ~clk;
  assign pins = {p_start, p_stop, p_origin, key_rst, ext_rst, en, t_hi, p_test,
                 code};

  pjsc_plc plc (.clk(clk), .start(p_start), .stop(p_stop),
    .origin(p_origin), .test_ok(p_test));
  pjsc_core uut (.clk(clk), .nrst(nrst), .pins(pins), .cfg(cfg),
    .active_job(active_job), .press_go(go), .piece_good(good),
    .piece_rejected(rej), .reject_locked(locked), .enable_missing(missing),
    .test_trigger(trig));

  task automatic tally_and_finish();
    $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [3:0] exp,
                     input logic [3:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // k picks where test 1 is absent: 0 start, 1 stop, 2 rest, 3 mid-press;
  // a refused start checks missing enable against flag instead
  task automatic run_cycle(input int k, input logic exp_go, input logic trg,
                           input logic flag);
    plc.step({3'h4, k != 0});
    tick(4);
    chk("go", {3'h0, exp_go}, {3'h0, go});
    if (!exp_go)
    begin
      chk("missing", {3'h0, flag}, {3'h0, missing});
      plc.step(4'h3);
      tick(4);
      return;
    end
    chk("trigger", {3'h0, trg}, {3'h0, trig});
    if (k == 3)
    begin
      plc.step(4'h8);
      plc.step(4'h9);
    end
    plc.step({3'h2, k != 1});
    tick(4);
    chk("stop go,good,rej", 4'h0, {1'b0, go, good, rej});
    plc.step({3'h1, k != 2});
    tick(4);
    chk("result", {1'b0, !flag, flag, flag}, {1'b0, good, rej, locked});
    plc.step(4'h3);
  endtask

  task automatic unlock(input logic key);
    if (key)
      key_rst = 1'b1;
    else
      ext_rst = 1'b1;
    tick(2);
    key_rst = 1'b0;
    ext_rst = 1'b0;
    tick(4);
  endtask

  initial
  begin
    cfg.job_select_on = 1'b1;
    cfg.enable_used = 3'h7;
    repeat (12) @(posedge clk);
    #1;
    nrst = 1'b1;
    tick(3);
    chk("outputs", 4'h0, {go, good, rej, locked});
    chk("job", 4'h0, active_job);
    foreach (codes[i])
    begin
      code = codes[i];
      tick(4);
      chk("job", codes[i], active_job);
    end
    plc.step(4'h9);
    tick(1);
    code = 4'h9;
    tick(4);
    chk("job in start", 4'h3, active_job);
    plc.step(4'h5);
    plc.step(4'h3);
    tick(4);
    chk("good", 4'h1, {3'h0, good});
    code = 4'h6;
    tick(4);
    chk("job", 4'h6, active_job);
    en = 3'h5;
    run_cycle(9, 1'b0, 1'b0, 1'b1);
    en = 3'h7;
    tick(4);
    chk("missing", 4'h0, {3'h0, missing});
    cfg.test_used = 3'h1;
    for (int m = 0; m < 4; m++)
      for (int k = (m == 3) ? 2 : 0; k < 4; k++)
      begin
        cfg.test_mode[0] = pjsc_pkg::pjsc_tmode_t'(m);
        run_cycle(k, 1'b1, 1'b1, k == m);
        if (k == m)
        begin
          run_cycle(9, 1'b0, 1'b0, 1'b0);
          cfg.key_reset_off = (m == 3);
          unlock(1'b1);
          chk("locked", {3'h0, m == 3}, {3'h0, locked});
          unlock(1'b0);
          chk("lock,rej", 4'h0, {2'h0, locked, rej});
        end
      end
    cfg.test_mode[0] = 3'h4;
    run_cycle(0, 1'b0, 1'b0, 1'b1);
    run_cycle(9, 1'b1, 1'b1, 1'b0);
    cfg.test_mode[0] = 3'h0;
    cfg.test_used = 3'h2;
    cfg.test_mode[1] = 3'h1;
    t_hi = 2'h2;
    run_cycle(9, 1'b1, 1'b0, 1'b1);
    t_hi = 2'h3;
    unlock(1'b0);
    chk("lock2", 4'h0, {3'h0, locked});
    cfg.job_select_on = 1'b0;
    code = 4'hc;
    tick(4);
    chk("job off", 4'h6, active_job);
    cfg.exclude_checks = 1'b1;
    run_cycle(0, 1'b1, 1'b0, 1'b0);
    tally_and_finish();
  end
endmodule
